// ### rtl/acr_pkg.sv
// Shared constants, register layouts and types of the converter control.
// Assumes a 32-bit APB slave in front and an analog core that converts
// on a start pulse and presents a ten-bit result.
package acr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ACR_ADDR_W = 12;
    localparam logic [7:0] ACR_IDX_RES_LOW = 8'h78;
    localparam logic [7:0] ACR_IDX_RES_HIGH = 8'h79;
    localparam logic [7:0] ACR_IDX_CTRL = 8'h7a;
    localparam logic [7:0] ACR_IDX_TRIG = 8'h7b;
    localparam logic [7:0] ACR_IDX_INSEL = 8'h7c;
    localparam logic [7:0] ACR_CTRL_RESET = 8'h00;
    localparam logic [7:0] ACR_INSEL_RESET = 8'h00;
    localparam logic [2:0] ACR_TRIG_RESET = 3'h0;
    localparam logic [2:0] ACR_TRIG_FREE_RUN = 3'h0;

    // Byte address of a register is four times its index
    function automatic logic [ACR_ADDR_W-1:0] acr_addr_of
    (
        input logic [7:0] idx
    );
        acr_addr_of = {2'b00, idx, 2'b00};
    endfunction : acr_addr_of

    // ****************************************************************
    // Register layouts
    // ****************************************************************
    typedef struct packed {
        logic converter_on;
        logic conversion_go;
        logic auto_trigger_on;
        logic conversion_done_flag;
        logic done_irq_enable;
        logic [2:0] conv_clock_divider;
    } acr_ctrl_type;

    typedef struct packed {
        logic [1:0] reference_select;
        logic left_align_result;
        logic [4:0] channel_gain_select;
    } acr_insel_type;

    // ****************************************************************
    // Converter core interface
    // ****************************************************************
    localparam logic [1:0] ACR_REF_EXTERNAL = 2'h0;
    localparam logic [1:0] ACR_REF_SUPPLY = 2'h1;
    localparam logic [1:0] ACR_REF_INT_1V1 = 2'h2;
    localparam logic [1:0] ACR_REF_INT_2V56 = 2'h3;
    localparam logic [1:0] ACR_GAIN_1X = 2'h0;
    localparam logic [1:0] ACR_GAIN_10X = 2'h1;
    localparam logic [1:0] ACR_GAIN_200X = 2'h2;
    localparam logic [3:0] ACR_POS_BANDGAP = 4'h8;
    localparam logic [3:0] ACR_POS_GROUND = 4'h9;
    localparam logic [4:0] ACR_CHAN_BANDGAP = 5'h1e;
    localparam logic [4:0] ACR_CHAN_GROUND = 5'h1f;
    localparam logic [2:0] ACR_NEG_IN0 = 3'h0;
    localparam logic [2:0] ACR_NEG_IN1 = 3'h1;
    localparam logic [2:0] ACR_NEG_IN2 = 3'h2;

    typedef struct packed {
        logic differential;
        logic [3:0] pos_sel;
        logic [2:0] neg_sel;
        logic [1:0] gain;
    } acr_route_type;

    typedef struct packed {
        logic converter_on;
        logic start;
        logic init;
        logic [1:0] reference_select;
        acr_route_type route;
    } acr_core_type;

    localparam logic [4:0] ACR_NORMAL_CYCLES = 5'h0d;
    localparam logic [4:0] ACR_INIT_CYCLES = 5'h19;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b01,
        ACR_CONV = 2'b10
    } acr_state_type;

    // Terminal count of the conversion clock divider (divide = count + 1)
    function automatic logic [6:0] acr_div_limit
    (
        input logic [2:0] code
    );
        case (code)
            3'h0, 3'h1: acr_div_limit = 7'h01;
            3'h2: acr_div_limit = 7'h03;
            3'h3: acr_div_limit = 7'h07;
            3'h4: acr_div_limit = 7'h0f;
            3'h5: acr_div_limit = 7'h1f;
            3'h6: acr_div_limit = 7'h3f;
            default: acr_div_limit = 7'h7f;
        endcase
    endfunction : acr_div_limit

    // Multiplexer and gain decode of the five-bit channel code
    function automatic acr_route_type acr_decode_channel
    (
        input logic [4:0] chan
    );
        acr_route_type r;
        r = '0;
        if (chan == ACR_CHAN_BANDGAP)
        begin
            r.pos_sel = ACR_POS_BANDGAP;
        end
        else if (chan == ACR_CHAN_GROUND)
        begin
            r.pos_sel = ACR_POS_GROUND;
        end
        else if (chan[4:3] == 2'b00)
        begin
            r.pos_sel = {1'b0, chan[2:0]};
        end
        else if (chan[4:3] == 2'b01)
        begin
            r.differential = 1'b1;
            r.pos_sel = {2'b00, chan[2], chan[0]};
            r.neg_sel = chan[2] ? ACR_NEG_IN2 : ACR_NEG_IN0;
            r.gain = chan[1] ? ACR_GAIN_200X : ACR_GAIN_10X;
        end
        else
        begin
            r.differential = 1'b1;
            r.pos_sel = {1'b0, chan[2:0]};
            r.neg_sel = chan[3] ? ACR_NEG_IN2 : ACR_NEG_IN1;
            r.gain = ACR_GAIN_1X;
        end
        acr_decode_channel = r;
    endfunction : acr_decode_channel

endpackage : acr_pkg

// ### rtl/acr_prescaler.sv
// Conversion clock divider: one-cycle tick at the selected rate.
// Assumes run and limit come from logic on pclk.
`timescale 1ns/10ps
module acr_prescaler
#(
    parameter int CW = 7
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [CW-1:0] limit,
    output logic tick
);

    logic [CW-1:0] count;
    wire logic at_limit = (count >= limit);

    // Held at zero while the converter is off so the first tick is a full
    // period after switching on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count <= (!run || at_limit) ? '0 : count + 1'b1;
            tick <= run && at_limit;
        end
    end

endmodule : acr_prescaler

// ### rtl/acr_converter_ctrl.sv
// Control and status registers of the ten-bit converter, with sequencing.
// Assumes an APB master on pclk, trigger sources and the interrupt
// acknowledge synchronous to pclk, and a core result valid at conversion
// end.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - Reference field picks external, supply, 1.1V, 2.56V
// - Reference change waits for conversion end
// - Alignment bit reshapes data register immediately
// - Single-ended inputs 0-7, bandgap, ground codes
// - Differential pairs at 1x, 10x and 200x gain
// - Channel change waits for conversion end
// - Enable on; disable stops and aborts conversion
// - Go starts single, or first free-running conversion
// - First conversion after enable takes 25 cycles
// - Go reads busy; writing zero does nothing
// - Auto trigger on rising edge of source
// - Done flag set at conversion end, even when the lock holds the result
// - Interrupt when flag, enable, global enable set
// - Flag cleared by vector or written one
// - Prescaler divides by 2 up to 128
// - Low byte read freezes result until high read
// - Free-running code retriggers; switching to it doesn't
// - Differential results two's complement, single unsigned
module acr_converter_ctrl
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:1] trigger_sources,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic [9:0] core_result,
    output acr_pkg::acr_core_type core_ctrl,
    output logic conv_irq
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    acr_pkg::acr_ctrl_type ctrl;
    acr_pkg::acr_insel_type insel;
    acr_pkg::acr_state_type state;
    logic [2:0] trigger_source_select;
    logic [9:0] result;
    logic result_lock;
    logic init_pending;
    logic conv_long;
    logic [4:0] tick_count;
    logic trig_prev;
    logic conv_tick;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire logic setup = psel && !penable;
    wire logic access = psel && penable && pready;
    wire logic hit_low = (paddr == acr_pkg::acr_addr_of(
        acr_pkg::ACR_IDX_RES_LOW));
    wire logic hit_high = (paddr == acr_pkg::acr_addr_of(
        acr_pkg::ACR_IDX_RES_HIGH));
    wire logic hit_ctrl = (paddr == acr_pkg::acr_addr_of(
        acr_pkg::ACR_IDX_CTRL));
    wire logic hit_trig = (paddr == acr_pkg::acr_addr_of(
        acr_pkg::ACR_IDX_TRIG));
    wire logic hit_insel = (paddr == acr_pkg::acr_addr_of(
        acr_pkg::ACR_IDX_INSEL));
    wire logic mapped = hit_low || hit_high || hit_ctrl || hit_trig
        || hit_insel;
    wire logic wr_en = access && pwrite && mapped;
    wire logic ctrl_wr = wr_en && hit_ctrl;
    wire logic insel_wr = wr_en && hit_insel;
    wire logic trig_wr = wr_en && hit_trig;
    wire acr_pkg::acr_ctrl_type wctrl = acr_pkg::acr_ctrl_type'(pwdata[7:0]);
    // Result-byte reads act in the setup cycle, the same edge that
    // samples their data, so the pair stays coherent with no gap
    wire logic rd_low = setup && !pwrite && hit_low;
    wire logic rd_high = setup && !pwrite && hit_high;

    // ****************************************************************
    // Conversion sequencing
    // ****************************************************************
    wire logic busy = (state == acr_pkg::ACR_CONV);
    wire logic on_eff = ctrl_wr ? wctrl.converter_on : ctrl.converter_on;
    wire logic [4:0] conv_len = conv_long ? acr_pkg::ACR_INIT_CYCLES
        : acr_pkg::ACR_NORMAL_CYCLES;
    wire logic conv_end = busy && on_eff && conv_tick
        && (tick_count == conv_len - 5'h01);
    wire logic go_req = ctrl_wr && wctrl.conversion_go;
    wire logic free_run = (trigger_source_select
        == acr_pkg::ACR_TRIG_FREE_RUN);
    // Code 000 selects a constant low, so moving to it never makes an edge
    wire logic trig_now = free_run ? 1'b0
        : trigger_sources[trigger_source_select];
    wire logic trig_edge = ctrl.auto_trigger_on && trig_now
        && !trig_prev;
    wire logic free_retrig = conv_end && ctrl.auto_trigger_on
        && free_run;
    wire logic start = on_eff && (!busy || conv_end)
        && (go_req || trig_edge || free_retrig);
    wire logic flag_clear = (ctrl_wr && wctrl.conversion_done_flag)
        || irq_vector_ack;
    wire logic route_update = !busy || conv_end;

    acr_pkg::acr_state_type next_state;
    assign next_state = !on_eff ? acr_pkg::ACR_IDLE
        : start ? acr_pkg::ACR_CONV
        : conv_end ? acr_pkg::ACR_IDLE
        : state;

    acr_prescaler #(
        .CW(7)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl.converter_on),
        .limit(acr_pkg::acr_div_limit(ctrl.conv_clock_divider)),
        .tick(conv_tick)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= acr_pkg::ACR_IDLE;
            tick_count <= '0;
            conv_long <= 1'b0;
            init_pending <= 1'b1;
            trig_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            trig_prev <= trig_now;
            if (start)
            begin
                tick_count <= '0;
                conv_long <= init_pending;
            end
            else if (busy && conv_tick)
            begin
                tick_count <= tick_count + 5'h01;
            end
            // While off the next conversion must re-initialise the core
            if (!on_eff)
            begin
                init_pending <= 1'b1;
            end
            else if (start)
            begin
                init_pending <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= acr_pkg::acr_ctrl_type'(acr_pkg::ACR_CTRL_RESET);
            insel <= acr_pkg::acr_insel_type'(acr_pkg::ACR_INSEL_RESET);
            trigger_source_select <= acr_pkg::ACR_TRIG_RESET;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ctrl.converter_on <= wctrl.converter_on;
                ctrl.auto_trigger_on <= wctrl.auto_trigger_on;
                ctrl.done_irq_enable <= wctrl.done_irq_enable;
                ctrl.conv_clock_divider <= wctrl.conv_clock_divider;
            end
            // A new completion beats a clear in the same cycle
            ctrl.conversion_done_flag <= conv_end
                || (ctrl.conversion_done_flag && !flag_clear);
            if (insel_wr)
            begin
                insel <= acr_pkg::acr_insel_type'(pwdata[7:0]);
            end
            if (trig_wr)
            begin
                trigger_source_select <= pwdata[2:0];
            end
        end
    end

    // ****************************************************************
    // Result capture and byte-pair lock
    // ****************************************************************
    // A conversion ending while locked keeps the old result; the flag
    // still rises, so software sees the later result as lost
    wire logic result_block = result_lock || rd_low;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result <= '0;
            result_lock <= 1'b0;
        end
        else
        begin
            if (conv_end && !result_block)
            begin
                result <= core_result;
            end
            if (rd_high)
            begin
                result_lock <= 1'b0;
            end
            else if (rd_low)
            begin
                result_lock <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Core drive and interrupt
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_ctrl <= '0;
            conv_irq <= 1'b0;
        end
        else
        begin
            core_ctrl.converter_on <= on_eff;
            core_ctrl.start <= start;
            core_ctrl.init <= start ? init_pending : core_ctrl.init;
            if (route_update)
            begin
                core_ctrl.reference_select <= insel.reference_select;
                core_ctrl.route <= acr_pkg::acr_decode_channel(
                    insel.channel_gain_select);
            end
            conv_irq <= ctrl.conversion_done_flag && ctrl.done_irq_enable
                && global_irq_enable && !flag_clear;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Alignment is applied at read time so it follows the bit at once
    wire logic [7:0] low_byte = insel.left_align_result
        ? {result[1:0], 6'h00} : result[7:0];
    wire logic [7:0] high_byte = insel.left_align_result
        ? result[9:2] : {6'h00, result[9:8]};
    wire logic [7:0] ctrl_read = {ctrl.converter_on, busy,
        ctrl.auto_trigger_on, ctrl.conversion_done_flag,
        ctrl.done_irq_enable, ctrl.conv_clock_divider};
    wire logic [7:0] read_byte = hit_low ? low_byte
        : hit_high ? high_byte
        : hit_ctrl ? ctrl_read
        : hit_trig ? {5'h00, trigger_source_select}
        : hit_insel ? insel
        : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? {24'h00_0000, read_byte}
                : prdata;
        end
    end

endmodule : acr_converter_ctrl

// ### test/acr_converter_ctrl_monitor.sv
// Port checker of the converter control block.
// Bound into acr_converter_ctrl; reads its ports and drives nothing.
`timescale 1ns/10ps
module acr_converter_ctrl_monitor
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire acr_pkg::acr_core_type core_ctrl,
    input wire logic conv_irq
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // Bus and conversion properties
    // ****************************************************************
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    go_spacing_a: assert property (
        core_ctrl.start |=> !core_ctrl.start [*8])
        else $error("start repeated within a conversion");
    go_needs_on_a: assert property (
        core_ctrl.start |-> core_ctrl.converter_on)
        else $error("start while converter off");
    ref_hold_a: assert property (core_ctrl.start |=>
        ($stable(core_ctrl.reference_select) || !core_ctrl.converter_on) [*8])
        else $error("reference moved during conversion");
    route_hold_a: assert property (core_ctrl.start |=>
        ($stable(core_ctrl.route) || !core_ctrl.converter_on) [*8])
        else $error("channel moved during conversion");
    irq_global_a: assert property (
        conv_irq |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
    irq_ack_a: assert property (irq_vector_ack |=> !conv_irq)
        else $error("interrupt stays after vector");
endmodule : acr_converter_ctrl_monitor

bind acr_converter_ctrl acr_converter_ctrl_monitor
    acr_converter_ctrl_monitor_inst
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
    .core_ctrl(core_ctrl), .conv_irq(conv_irq)
);

// ### test/acr_core_model.sv
// Behavioural analog core facing the converter control.
// Assumes start is a one-cycle pulse on pclk.
`timescale 1ns/10ps
module acr_core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire acr_pkg::acr_core_type core_ctrl,
    output logic [9:0] core_result
);
    // Echo the route seen at start, so a late or stale route shows
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_result <= 10'h3ff;
        else if (core_ctrl.start)
            core_result <= core_ctrl.route;
    end
endmodule : acr_core_model

// ### test/test_acr_converter_ctrl.sv
// Self-checking bench of the converter control over APB.
// Assumes the core model answers with the route latched at start.
`timescale 1ns/10ps
module test_acr_converter_ctrl;
    localparam logic [7:0] CT = acr_pkg::ACR_IDX_CTRL;
    localparam logic [7:0] IN = acr_pkg::ACR_IDX_INSEL;
    localparam logic [7:0] TR = acr_pkg::ACR_IDX_TRIG;
    localparam logic [7:0] LO = acr_pkg::ACR_IDX_RES_LOW;
    localparam logic [7:0] HI = acr_pkg::ACR_IDX_RES_HIGH;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:1] trig = 7'h00;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic [31:0] prdata, q;
    logic pready, pslverr, conv_irq, e;
    logic [9:0] core_result;
    acr_pkg::acr_core_type core_ctrl;
    int fails = 0;
    int cmp_count = 0;
    int starts = 0;
    int cyc = 0;
    int n, dv, s0;
    logic [1:0] rf;

    acr_converter_ctrl acr_converter_ctrl_inst
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_sources(trig),
        .global_irq_enable(gie), .irq_vector_ack(ack),
        .core_result(core_result), .core_ctrl(core_ctrl),
        .conv_irq(conv_irq)
    );
    acr_core_model acr_core_model_inst
    (
        .pclk(pclk), .presetn(presetn), .core_ctrl(core_ctrl),
        .core_result(core_result)
    );

    // ****************************************************************
    // Clock, start counter and hang limit
    // ****************************************************************
    initial
    begin
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (core_ctrl.start === 1'b1)
            starts <= starts + 1;
        if (cyc == 40000)
        begin
            fails++;
            print_verdict();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] ex,
        input logic [31:0] got);
        cmp_count++;
        if (got !== ex)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench cycle limit ends this wait
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h00_0000, d});
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
        apb(1'b0, idx, 32'h0000_0000);
        chk("register", {24'h00_0000, ex}, q);
    endtask : rd

    task automatic wait_irq();
        n = 0;
        while (conv_irq !== 1'b1 && n < 4000)
        begin
            @(posedge pclk);
            n++;
        end
        chk("irq wait", 1, n < 4000);
    endtask : wait_irq

    function automatic logic [9:0] exp_route(input logic [4:0] c);
        if (c < 5'h08)
            return {2'b00, c[2:0], 5'h00};
        if (c < 5'h10)
            return {3'b100, c[2], c[0], 1'b0, c[2], 1'b0, c[1], !c[1]};
        if (c < 5'h18)
            return {2'b10, c[2:0], 3'h1, 2'h0};
        if (c < 5'h1e)
            return {2'b10, c[2:0], 3'h2, 2'h0};
        return {1'b0, c[0] ? acr_pkg::ACR_POS_GROUND :
            acr_pkg::ACR_POS_BANDGAP, 5'h00};
    endfunction : exp_route

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CT, 8'h00);
        rd(IN, 8'h00);
        rd(TR, 8'h00);
        rd(LO, 8'h00);
        // Releases the byte-pair lock taken by the low read
        rd(HI, 8'h00);
        apb(1'b0, 8'h7d, 32'h0000_0000);
        chk("unmapped error", 1, e);
        for (int c = 0; c < 32; c++)
        begin
            // Differential codes only get supply or 2.56V internal
            rf = (c < 8) ? c[1:0] : {c[1], 1'b1};
            wr(IN, {rf, 1'b0, c[4:0]});
            repeat (2) @(posedge pclk);
            chk("route", exp_route(c[4:0]), core_ctrl.route);
            chk("ref", rf, core_ctrl.reference_select);
        end
        gie <= 1'b1;
        wr(IN, 8'h03);
        wr(CT, 8'hc8);
        wait_irq();
        chk("first length", 1, n >= 48 && n <= 55);
        chk("init", 1, core_ctrl.init);
        rd(CT, 8'h98);
        rd(LO, 8'h60);
        rd(HI, 8'h00);
        wr(IN, 8'h23);
        rd(LO, 8'h00);
        rd(HI, 8'h18);
        gie <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq", 0, conv_irq);
        gie <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("irq", 1, conv_irq);
        wr(CT, 8'h88);
        rd(CT, 8'h98);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        rd(CT, 8'h88);
        chk("irq", 0, conv_irq);
        for (int d = 0; d < 8; d++)
        begin
            dv = (d < 2) ? 2 : (1 << d);
            wr(CT, 8'hc8 | d[7:0]);
            wait_irq();
            chk("length", 1, n >= 12 * dv && n <= 13 * dv + 4);
            chk("init", 0, core_ctrl.init);
            wr(CT, 8'h98 | d[7:0]);
            rd(CT, 8'h88 | d[7:0]);
        end
        wr(CT, 8'hcf);
        rd(CT, 8'hcf);
        wr(IN, 8'hc9);
        repeat (4) @(posedge pclk);
        chk("route", 10'h060, core_ctrl.route);
        chk("ref", 0, core_ctrl.reference_select);
        wait_irq();
        repeat (2) @(posedge pclk);
        chk("route", 10'h221, core_ctrl.route);
        chk("ref", 3, core_ctrl.reference_select);
        wr(CT, 8'h9f);
        rd(LO, 8'h60);
        wr(CT, 8'hc8);
        wait_irq();
        rd(HI, 8'h00);
        wr(CT, 8'h98);
        wr(CT, 8'hc8);
        wait_irq();
        rd(LO, 8'h21);
        rd(HI, 8'h02);
        // Flag cleared with the start so an abort shows as no flag
        wr(CT, 8'hdf);
        repeat (10) @(posedge pclk);
        wr(CT, 8'h0f);
        repeat (1800) @(posedge pclk);
        rd(CT, 8'h0f);
        chk("core on", 0, core_ctrl.converter_on);
        s0 = starts;
        wr(CT, 8'h88);
        repeat (100) @(posedge pclk);
        chk("starts", s0, starts);
        wr(CT, 8'hc8);
        wait_irq();
        chk("first length", 1, n >= 48 && n <= 55);
        wr(CT, 8'h98);
        for (int k = 1; k < 8; k++)
        begin
            wr(TR, k[7:0]);
            wr(CT, 8'ha8);
            s0 = starts;
            trig <= 7'(1 << (k % 7));
            repeat (80) @(posedge pclk);
            chk("starts", s0, starts);
            trig <= 7'(1 << (k - 1));
            repeat (80) @(posedge pclk);
            chk("starts", s0 + 1, starts);
            trig <= 7'h00;
            wr(CT, 8'h98);
        end
        wr(TR, 8'h01);
        wr(CT, 8'hc8);
        wait_irq();
        wr(CT, 8'ha8);
        s0 = starts;
        wr(TR, 8'h00);
        repeat (60) @(posedge pclk);
        chk("starts", s0, starts);
        wr(CT, 8'he8);
        repeat (200) @(posedge pclk);
        chk("free run", 1, starts >= s0 + 4);
        wr(CT, 8'h00);
        print_verdict();
    end
endmodule : test_acr_converter_ctrl
